// File: rtl/scs_pkg.sv
`default_nettype none
package scs_pkg;

    // ------------------------------------------------------------
    // Register location and layout
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_ADDR = 8'ha1;   // Register address
    localparam logic [3:0] SFR_PAGE = 4'h0;    // Register page
    localparam logic [7:0] RESET_VAL = 8'h07;  // Value after reset
    localparam int BIT_BUSY = 7;               // Transfer busy
    localparam int BIT_MASTER = 6;             // Master select
    localparam int BIT_PHASE = 5;              // Clock phase
    localparam int BIT_IDLE = 4;               // Clock idle level
    localparam int BIT_SELECTED = 3;           // De-glitched select
    localparam int BIT_RAW_SEL = 2;            // Raw select pin
    localparam int BIT_SR_EMPTY = 1;           // Shift register empty
    localparam int BIT_RX_EMPTY = 0;           // Receive buffer empty
    localparam logic [7:0] WR_MASK = 8'h70;    // Writable bits

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;         // Core clock period
    localparam int GLITCH_NS = 40;             // Least stable time
    localparam int GLITCH_CYC =
        (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] GLITCH_CNT = 3'(GLITCH_CYC); // Filter count
    localparam logic [3:0] MST_HALF = 4'h4;    // Master half period
    localparam logic [2:0] BITS_LAST = 3'h7;   // Last bit index

    // Link pins sampled together
    typedef struct packed {
        logic sck;   // Serial clock
        logic mosi;  // Master out
        logic miso;  // Master in
        logic sel_n; // Slave select, active low
    } scs_pins_type;

    // Register bus request
    typedef struct packed {
        logic [3:0] page;  // Register page
        logic [7:0] addr;  // Register address
        logic [7:0] wdata; // Write data
        logic wr;          // Write strobe
        logic rd;          // Read strobe
    } scs_bus_type;

endpackage : scs_pkg
`default_nettype wire

// File: rtl/scs_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Two-stage synchroniser with optional stable-level filter
// ----------------------------------------------------------------
module scs_sync #(
    parameter logic INIT = 1'b0,        // Reset level
    parameter logic [2:0] FILT = 3'h0   // Cycles of stability, 0 = none
) (
    input wire logic clk_sys,  // Core clock
    input wire logic rst,      // Sync reset
    input wire logic din,      // Async input
    output logic sync,         // Two-flop copy
    output logic filt          // Filtered copy
);
    logic meta_reg;            // First stage, read only by sync
    logic [2:0] cnt_reg;       // Stability counter

    // Plain two-flop chain
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_reg <= INIT;
            sync <= INIT;
        end else begin
            meta_reg <= din;
            sync <= meta_reg;
        end
    end

    // Filter: only a level held FILT+1 cycles passes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= 3'h0;
            filt <= INIT;
        end else if (sync == filt) begin
            cnt_reg <= 3'h0;
        end else if (cnt_reg >= FILT) begin
            filt <= sync;
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
endmodule : scs_sync
`default_nettype wire

// File: rtl/scs_cfg.sv
// Contract
// - Busy flag high during any transfer
// - Master select bit picks master or slave
// - Phase bit picks first or second edge
// - Idle level bit sets clock rest level
// - Selected flag follows de-glitched select low
// - Raw pin bit shows instantaneous select
// - Slave shift empty set done, cleared activity
// - Master reports shift empty as one
// - Slave receive empty cleared by unread data
// - Master reports receive empty as one
// - Slave samples MOSI at bit centre
// - Master samples MISO one clock early
// - Register at address a1, page 0
// - Both ends share phase and idle level
`timescale 1ns/10ps
`default_nettype none
module scs_cfg (
    input wire logic clk_sys,                   // Core clock, 50 MHz
    input wire logic rst,                       // Sync reset, active high
    input wire scs_pkg::scs_bus_type bus,       // Register access
    input wire logic port_enable_bit,           // Port enable
    input wire logic tx_load,                   // Byte into transmit buffer
    input wire logic rx_read,                   // Receive buffer read
    input wire logic [7:0] tx_data,             // Byte to send
    input wire logic sck_in,                    // Serial clock pin
    input wire logic mosi_in,                   // Master out pin
    input wire logic miso_in,                   // Master in pin
    input wire logic sel_n_in,                  // Select pin, active low
    output logic [7:0] rdata,                   // Read data
    output logic sck_out,                       // Serial clock drive
    output logic sck_oe,                        // Serial clock enable
    output logic mosi_out,                      // Master out drive
    output logic miso_out,                      // Master in drive
    output logic miso_oe,                       // Master in enable
    output logic [7:0] rx_data,                 // Received byte
    output logic rx_valid                       // Unread byte present
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    scs_pkg::scs_pins_type pin_s;   // Synchronised pins
    logic sel_n_filt;               // De-glitched select

    scs_sync #(.INIT(1'b0), .FILT(3'h0)) u_sck (.clk_sys(clk_sys),
        .rst(rst), .din(sck_in), .sync(pin_s.sck), .filt());
    scs_sync #(.INIT(1'b0), .FILT(3'h0)) u_mosi (.clk_sys(clk_sys),
        .rst(rst), .din(mosi_in), .sync(pin_s.mosi), .filt());
    scs_sync #(.INIT(1'b0), .FILT(3'h0)) u_miso (.clk_sys(clk_sys),
        .rst(rst), .din(miso_in), .sync(pin_s.miso), .filt());
    // Select gets the filter too; raw copy serves the pin bit
    scs_sync #(.INIT(1'b1), .FILT(scs_pkg::GLITCH_CNT)) u_sel (
        .clk_sys(clk_sys), .rst(rst), .din(sel_n_in), .sync(pin_s.sel_n),
        .filt(sel_n_filt));

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic master_reg;   // Master select bit
    logic phase_reg;    // Clock phase select
    logic idle_reg;     // Clock idle level
    logic hit;          // Address decode

    assign hit = (bus.addr == scs_pkg::SFR_ADDR)
        && (bus.page == scs_pkg::SFR_PAGE);

    // Only the three control bits store; status bits ignore writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            master_reg <= scs_pkg::RESET_VAL[scs_pkg::BIT_MASTER];
            phase_reg <= scs_pkg::RESET_VAL[scs_pkg::BIT_PHASE];
            idle_reg <= scs_pkg::RESET_VAL[scs_pkg::BIT_IDLE];
        end else if (bus.wr && hit) begin
            master_reg <= bus.wdata[scs_pkg::BIT_MASTER];
            phase_reg <= bus.wdata[scs_pkg::BIT_PHASE];
            idle_reg <= bus.wdata[scs_pkg::BIT_IDLE];
        end
    end

    // ------------------------------------------------------------
    // Shared shift engine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} scs_st_type;
    scs_st_type st_reg;         // Master sequencer state
    logic [3:0] div_reg;        // Master half-period counter
    logic [2:0] bit_reg;        // Bit index
    logic [7:0] shift_reg;      // Shift register
    logic [7:0] txbuf_reg;      // Transmit buffer
    logic txfull_reg;           // Transmit buffer holds a byte
    logic sr_empty_reg;         // Shift register empty (slave)
    logic sck_d_reg;            // Previous synchronised clock
    logic busy;                 // Transfer in progress
    logic slv_act;              // Slave active
    logic sck_lvl;              // Clock with idle level removed
    logic lead_edge;            // First edge of bit
    logic trail_edge;           // Second edge of bit
    logic samp_s;               // Slave sample moment
    logic last_edge;            // Final clock edge of a byte
    logic done_s;               // Slave byte done
    logic m_samp;               // Master sample moment
    logic m_done;               // Master byte done

    assign slv_act = port_enable_bit && !master_reg && !sel_n_filt;
    assign sck_lvl = pin_s.sck ^ idle_reg;
    assign lead_edge = slv_act && sck_lvl && !(sck_d_reg ^ idle_reg);
    assign trail_edge = slv_act && !sck_lvl && (sck_d_reg ^ idle_reg);
    // Phase 0 samples the first edge, phase 1 the second
    // Outgoing bit moves on the sample edge as well; the sync lag
    // still leaves it a full half bit ahead of the far end's sample
    assign samp_s = phase_reg ? trail_edge : lead_edge;
    // Eighth trailing edge ends a byte in either phase
    assign last_edge = trail_edge
        && (bit_reg == (phase_reg ? scs_pkg::BITS_LAST : 3'h0));
    assign done_s = samp_s && (bit_reg == scs_pkg::BITS_LAST);
    // One core clock before the bit ends
    assign m_samp = (st_reg == ST_TRAIL) && (div_reg == 4'h1);
    assign m_done = m_samp && (bit_reg == scs_pkg::BITS_LAST);
    assign busy = (st_reg != ST_IDLE)
        || (slv_act && (bit_reg != 3'h0 || !sr_empty_reg));

    // Previous clock level for edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sck_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= pin_s.sck;
        end
    end

    // Master sequencer: lead half then trail half for each bit
    always_ff @(posedge clk_sys) begin
        if (rst || !port_enable_bit || !master_reg) begin
            st_reg <= ST_IDLE;
            div_reg <= 4'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (txfull_reg) begin
                        st_reg <= ST_LEAD;
                        div_reg <= scs_pkg::MST_HALF;
                    end
                end
                ST_LEAD: begin
                    if (div_reg == 4'h1) begin
                        st_reg <= ST_TRAIL;
                        div_reg <= scs_pkg::MST_HALF;
                    end else begin
                        div_reg <= div_reg - 4'h1;
                    end
                end
                ST_TRAIL: begin
                    if (div_reg == 4'h1) begin
                        st_reg <= (bit_reg == scs_pkg::BITS_LAST)
                            ? ST_IDLE : ST_LEAD;
                        div_reg <= scs_pkg::MST_HALF;
                    end else begin
                        div_reg <= div_reg - 4'h1;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Shifting, bit count and transmit buffer
    always_ff @(posedge clk_sys) begin
        if (rst || !port_enable_bit) begin
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            txbuf_reg <= 8'h00;
            txfull_reg <= 1'b0;
        end else begin
            if (tx_load && !txfull_reg) begin
                txbuf_reg <= tx_data;
                txfull_reg <= 1'b1;
            end
            if (master_reg) begin
                if (st_reg == ST_IDLE && txfull_reg) begin
                    shift_reg <= txbuf_reg;
                    txfull_reg <= 1'b0;
                    bit_reg <= 3'h0;
                end else if (m_samp) begin
                    shift_reg <= {shift_reg[6:0], pin_s.miso};
                    bit_reg <= bit_reg + 3'h1;
                end
            end else if (sr_empty_reg && txfull_reg) begin
                // Empty register takes the byte at once, selected or not
                shift_reg <= txbuf_reg;
                txfull_reg <= 1'b0;
            end else if (sel_n_filt) begin
                bit_reg <= 3'h0;  // Deselect restarts the count
            end else if (samp_s) begin
                shift_reg <= {shift_reg[6:0], pin_s.mosi};
                bit_reg <= bit_reg + 3'h1;
            end
        end
    end

    // Slave shift register empty: loading or clock activity clears
    always_ff @(posedge clk_sys) begin
        if (rst || !port_enable_bit) begin
            sr_empty_reg <= 1'b1;
        end else if ((sr_empty_reg && txfull_reg) || lead_edge
            || trail_edge) begin
            sr_empty_reg <= last_edge;
        end
    end

    // Receive buffer: arrival loads only an empty buffer; one meeting a full buffer is dropped, even with a same-cycle read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end else if ((done_s || m_done) && !rx_valid) begin
            rx_data <= {shift_reg[6:0],
                master_reg ? pin_s.miso : pin_s.mosi};
            rx_valid <= 1'b1;
        end else if (rx_read) begin
            rx_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_oe <= port_enable_bit && master_reg;
            // Clock leaves idle in the second half when phase is 0
            sck_out <= idle_reg ^ ((st_reg == ST_LEAD) == phase_reg
                && st_reg != ST_IDLE);
            mosi_out <= shift_reg[7];
            miso_out <= shift_reg[7];
            miso_oe <= slv_act;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= scs_pkg::RESET_VAL;
        end else if (bus.rd && hit) begin
            rdata <= {busy, master_reg, phase_reg, idle_reg,
                !sel_n_filt,
                pin_s.sel_n,
                master_reg ? 1'b1 : sr_empty_reg,
                master_reg ? 1'b1 : !rx_valid};
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : scs_cfg
`default_nettype wire

// File: verification/scs_cfg_props.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Register and link checks at the ports
// ------------------------------------------
module scs_cfg_props (
    input wire logic clk_sys,             // Core clock
    input wire logic rst,                 // Sync reset
    input wire scs_pkg::scs_bus_type bus, // Register access
    input wire logic port_enable_bit,     // Port enable
    input wire logic rx_read,             // Receive read
    input wire logic [7:0] rdata,         // Read data
    input wire logic sck_oe,              // Clock enable
    input wire logic rx_valid             // Unread byte
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic hit;           // Access lands here
    logic [2:0] cfg_reg; // Shadow of writable bits
    assign hit = bus.page == 4'h0 && bus.addr == 8'ha1;
    // Shadow lets reads be predicted
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_reg <= 3'h0;
        end else if (bus.wr && hit) begin
            cfg_reg <= bus.wdata[6:4];
        end
    end
    property p_miss; bus.rd && !hit |=> rdata == 8'h00; endproperty
    a_miss: assert property (p_miss) else $error("stray read data");
    property p_quiet; !bus.rd |=> rdata == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("data unasked");
    property p_back; bus.rd && hit |=> rdata[6:4] == $past(cfg_reg);
    endproperty
    a_back: assert property (p_back) else $error("config lost");
    property p_mflag; bus.rd && hit && cfg_reg[2] |=> rdata[1:0] == 2'b11;
    endproperty
    a_mflag: assert property (p_mflag) else $error("master flags");
    property p_rflag;
        bus.rd && hit && !cfg_reg[2] |=> rdata[0] == !$past(rx_valid);
    endproperty
    a_rflag: assert property (p_rflag) else $error("empty flag");
    property p_drv; !port_enable_bit || !cfg_reg[2] |=> !sck_oe; endproperty
    a_drv: assert property (p_drv) else $error("clock driven");
    property p_hold; rx_valid && !rx_read |=> rx_valid; endproperty
    a_hold: assert property (p_hold) else $error("byte vanished");
    property p_clr; rx_valid && rx_read |=> !rx_valid; endproperty
    a_clr: assert property (p_clr) else $error("byte not taken");
    c_read: cover property (bus.rd && hit);
    c_rx: cover property ($rose(rx_valid));
    c_mst: cover property ($rose(sck_oe));
endmodule : scs_cfg_props
bind scs_cfg scs_cfg_props chk_u (.clk_sys, .rst, .bus, .port_enable_bit,
    .rx_read, .rdata, .sck_oe, .rx_valid);
`default_nettype wire

// File: verification/scs_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Far end: leads or follows on the link
// ------------------------------------------
module scs_far_end (
    input wire logic sck_w,  // Resolved serial clock
    input wire logic mosi_w, // Master out level
    input wire logic miso_w, // Master in level
    output logic sck_drv,    // Clock when leading
    output logic mosi_drv,   // Data when leading
    output logic sel_n_drv,  // Select, active low
    output logic miso_drv    // Data when following
);
    logic ph, idle;          // Phase and rest level
    logic [7:0] tx_b, rx_b;  // Bytes out and in
    int idx;                 // Bit being shown
    initial begin
        {ph, idle, sck_drv, mosi_drv, sel_n_drv, miso_drv} = 6'h0b;
        idx = 0;
    end
    // Follower shifts on one edge and captures on the other
    always @(sck_w) begin
        if (sel_n_drv && ((sck_w != idle) == ph)) begin
            idx++;
        end else if (sel_n_drv) begin
            rx_b = {rx_b[6:0], mosi_w};
        end
        // Idle line keeps changing so no stale bit looks valid
        miso_drv = (idx >= 0 && idx < 8) ? tx_b[3'(7 - idx)] : ~miso_drv;
    end
    task automatic load(input logic p, i, input logic [7:0] b);
        {ph, idle, tx_b, sck_drv} = {p, i, b, i};
        #1;
        idx = p ? -1 : 0;
        miso_drv = p ? ~miso_drv : b[7];
    endtask : load
    // Leader: one byte, select held low around it
    task automatic send(input logic p, i, input logic [7:0] b);
        {ph, idle, sck_drv} = {p, i, i};
        #7;
        sel_n_drv = 1'b0;
        #160;
        // Leader captures the follower's bit on the sample edge
        for (int k = 7; k >= 0; k--) begin
            mosi_drv = p ? mosi_drv : b[k];
            #80;
            sck_drv = ~i;
            rx_b = p ? rx_b : {rx_b[6:0], miso_w};
            mosi_drv = p ? b[k] : mosi_drv;
            #80;
            sck_drv = i;
            rx_b = p ? {rx_b[6:0], miso_w} : rx_b;
        end
        #80;
        sel_n_drv = 1'b1;
        mosi_drv = ~mosi_drv;
    endtask : send
endmodule : scs_far_end
`default_nettype wire

// File: verification/scs_cfg_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("wrong value at %0t: %h not %h", $time, got, exp); \
    end \
end
// ------------------------------------------
// Bench: register map, master and slave runs
// ------------------------------------------
module scs_cfg_tb;
    logic clk_sys = 1'b0, rst = 1'b1;     // Clock and reset
    scs_pkg::scs_bus_type bus = '0;       // Register access
    logic en = 1'b0, tx_load = 1'b0, rx_read = 1'b0; // Controls
    logic [7:0] tx_data = 8'h00, rdata, rx_data; // Data
    logic sck_out, sck_oe, mosi_out, miso_out, miso_oe, rx_valid;
    logic p_sck, p_mosi, p_sel_n, p_miso; // Far end drives
    logic sck_w, mosi_w, miso_w;          // Resolved wires
    int miscompares = 0, checks_done = 0; // Tallies
    assign sck_w = sck_oe ? sck_out : p_sck;
    assign mosi_w = sck_oe ? mosi_out : p_mosi;
    assign miso_w = miso_oe ? miso_out : p_miso;
    always #10 clk_sys = ~clk_sys;
    scs_cfg dut_u (.clk_sys, .rst, .bus, .port_enable_bit(en), .tx_load,
        .rx_read, .tx_data, .sck_in(sck_w), .mosi_in(mosi_w),
        .miso_in(miso_w), .sel_n_in(p_sel_n), .rdata, .sck_out, .sck_oe,
        .mosi_out, .miso_out, .miso_oe, .rx_data, .rx_valid);
    scs_far_end far_u (.sck_w, .mosi_w, .miso_w, .sck_drv(p_sck),
        .mosi_drv(p_mosi), .sel_n_drv(p_sel_n), .miso_drv(p_miso));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // One strobe cycle; read data is settled on return
    task automatic acc(input logic [3:0] pg, input logic [7:0] ad, wd,
                       input logic w);
        @(negedge clk_sys);
        bus = '{pg, ad, wd, w, ~w};
        @(negedge clk_sys);
        bus = '0;
    endtask : acc
    task automatic rd;
        acc(4'h0, 8'ha1, 8'h00, 1'b0);
    endtask : rd
    task automatic wr(input logic [7:0] d);
        acc(4'h0, 8'ha1, d, 1'b1);
    endtask : wr
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    // Bounded wait; a hang ends the run
    task automatic wait_rx;
        for (int k = 0; k < 400 && rx_valid !== 1'b1; k++) begin
            @(negedge clk_sys);
        end
        if (rx_valid !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask : wait_rx
    task automatic t_regs;
        rd();
        `CHK(rdata, 8'h07)
        wr(8'hff);
        rd();
        `CHK(rdata, 8'h77)
        acc(4'h0, 8'ha2, 8'h00, 1'b1);
        acc(4'h1, 8'ha1, 8'h00, 1'b1);
        rd();
        `CHK(rdata, 8'h77)
        acc(4'h0, 8'ha2, 8'h00, 1'b0);
        `CHK(rdata, 8'h00)
        wr(8'h00);
    endtask : t_regs
    task automatic t_master(input logic p, i, input logic [7:0] b, s);
        en = 1'b0;
        wr({2'b01, p, i, 4'h0});
        en = 1'b1;
        cyc(4);
        `CHK(sck_out, i)
        far_u.load(p, i, s);
        tx_data = b;
        pulse(tx_load);
        cyc(8);
        rd();
        `CHK(rdata[7], 1'b1)
        wait_rx();
        `CHK(rx_data, s)
        `CHK(far_u.rx_b, b)
        cyc(8);
        rd();
        `CHK(rdata, {2'b01, p, i, 4'h7})
        `CHK(sck_out, i)
        pulse(rx_read);
    endtask : t_master
    task automatic t_slave(input logic p, i, input logic [7:0] b);
        en = 1'b0;
        far_u.load(p, i, 8'h00);
        wr({2'b00, p, i, 4'h0});
        en = 1'b1;
        tx_data = ~b;
        pulse(tx_load);
        cyc(4);
        rd();
        `CHK(rdata[1:0], 2'b01)
        fork
            far_u.send(p, i, b);
            begin
                cyc(30);
                rd();
                `CHK(rdata[7:2], {2'b10, p, i, 2'b10})
            end
        join
        wait_rx();
        `CHK(rx_data, b)
        `CHK(far_u.rx_b, ~b)
        cyc(8);
        rd();
        `CHK(rdata, {2'b00, p, i, 4'h6})
        pulse(rx_read);
        rd();
        `CHK(rdata[0], 1'b1)
    endtask : t_slave
    task automatic final_report;
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // Every phase and rest level in both roles
    initial begin
        cyc(3);
        rst = 1'b0;
        t_regs();
        for (int m = 0; m < 4; m++) begin
            t_master(m[1], m[0], 8'ha5 ^ 8'(m), 8'h3c + 8'(m));
            t_slave(m[1], m[0], 8'hc3 - 8'(m));
        end
        final_report();
    end
endmodule : scs_cfg_tb
`default_nettype wire
